// [core/quad_dac_ctrl.sv]
// Command control of a quad DAC behind a 24-bit serial link.
// Assumes the link clock stops outside frames and select stays high >= 5 core clocks.
//
// Contract
// - Write-and-update command loads input and DAC registers, ignoring load pin.
// - Chain-setup command stores data bit 0 as chain enable, default off.
// - Shift every serial clock while select low; excess bits leave on serial out.
// - Serial output changes on rising serial clock edge.
// - Frame ending off a multiple of 24 still executes.
// - Select rising latches the frame; shifting stops until select falls.
// - Readback selects one channel by single address bit; data bits ignored.
// - Readback with zero or several address bits reads channel A.
// - Next frame shifts out selected DAC register; top four bits undefined.
// - Serial output enabled for readback frame even when chain mode off.
// - Power command ignores address, loads two mode bits per channel, D highest.
// - Mode 00 normal, 01 1k to ground, 10 100k to ground, 11 three-state.
// - Power-down keeps DAC registers; updates still accepted while down.
// - Leaving power-down needs 4.5 us before output valid. Code skips the wait when a soft reset ends power-down.
// - Separate input and DAC register per channel, transfer under load pin.
// - Input write with load pin low updates input and DAC registers.
// - Input write with load pin high updates input only; load fall copies. Code ignores a load fall while a frame is in progress.
// - Frame is 24 bits MSB first: command, four per-channel address bits, data word.
// - Load-mask command sets per-channel masks; masked channels ignore load pin. Code masks only load fall; input write with pin low still loads DAC register.
// - Write, update and write-and-update commands apply to every channel whose address bit is set.
`timescale 1ns/1ps
`default_nettype none

module quad_dac_ctrl (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    // Serial link
    input  wire logic        i_sclk,
    input  wire logic        i_frame_sel_n,
    input  wire logic        i_serial_in,
    output logic             o_serial_out,
    output logic             o_serial_out_oe_n,
    // Load pin
    input  wire logic        i_load_update_n,
    // Channel outputs
    output logic [3:0][15:0] o_dac_code,
    output logic [7:0]       o_power_mode,
    output logic [3:0]       o_pd_1k,
    output logic [3:0]       o_pd_100k,
    output logic [3:0]       o_pd_hiz,
    output logic [3:0]       o_out_valid,
    // Settings
    output logic             o_chain_enable
);

    // ********************************
    // Carriers and helpers
    // ********************************
    link_if lk ();
    pwr_if  pw ();

    serial_shifter u_shifter (
        .i_sclk        (i_sclk),
        .i_resetn      (i_resetn),
        .i_frame_sel_n (i_frame_sel_n),
        .i_serial_in   (i_serial_in),
        .o_serial_out  (o_serial_out),
        .lk            (lk.shift)
    );

    power_ctrl u_power (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .pw         (pw.bank)
    );

    // ********************************
    // Pin synchronisers
    // ********************************
    logic [2:0] sel_sync_reg;
    logic [2:0] load_sync_reg;
    logic       sel_state_reg;
    logic       load_state_reg;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sel_sync_reg  <= 3'h7;
            load_sync_reg <= 3'h7;
        end else begin
            sel_sync_reg  <= {sel_sync_reg[1:0], i_frame_sel_n};
            load_sync_reg <= {load_sync_reg[1:0], i_load_update_n};
        end
    end

    wire sel_agree  = (sel_sync_reg[1] == sel_sync_reg[2]);
    wire load_agree = (load_sync_reg[1] == load_sync_reg[2]);
    wire sel_next   = sel_agree ? sel_sync_reg[2] : sel_state_reg;
    wire load_next  = load_agree ? load_sync_reg[2] : load_state_reg;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sel_state_reg  <= 1'b1;
            load_state_reg <= 1'b1;
        end else begin
            sel_state_reg  <= sel_next;
            load_state_reg <= load_next;
        end
    end

    // Select rise ends a frame whatever its clock count
    wire frame_done = sel_next && !sel_state_reg;
    // Load fall counts only while no frame is in progress
    wire load_fall  = !load_next && load_state_reg && sel_state_reg;
    wire load_low   = !load_state_reg;

    // ********************************
    // Frame decode
    // ********************************
    wire [3:0]  cmd  = lk.frame[quad_dac_pkg::CMD_MSB:quad_dac_pkg::CMD_LSB];
    wire [3:0]  addr = lk.frame[quad_dac_pkg::ADDR_MSB:quad_dac_pkg::ADDR_LSB];
    wire [15:0] data = lk.frame[quad_dac_pkg::DATA_MSB:quad_dac_pkg::DATA_LSB];

    // Unlisted codes raise no strobe at all
    wire do_wr_in  = frame_done && (cmd == quad_dac_pkg::CMD_WR_IN);
    wire do_update = frame_done && (cmd == quad_dac_pkg::CMD_UPDATE);
    wire do_wr_upd = frame_done && (cmd == quad_dac_pkg::CMD_WR_UPD);
    wire do_power  = frame_done && (cmd == quad_dac_pkg::CMD_POWER);
    wire do_mask   = frame_done && (cmd == quad_dac_pkg::CMD_MASK);
    wire do_swrst  = frame_done && (cmd == quad_dac_pkg::CMD_SWRST);
    wire do_chain  = frame_done && (cmd == quad_dac_pkg::CMD_CHAIN);
    wire do_rdbk   = frame_done && (cmd == quad_dac_pkg::CMD_RDBK);

    // ********************************
    // Settings
    // ********************************
    logic       chain_reg;
    logic [3:0] mask_reg;
    logic [7:0] power_mode_reg;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            chain_reg <= quad_dac_pkg::CHAIN_RST;
        end else if (do_swrst) begin
            chain_reg <= quad_dac_pkg::CHAIN_RST;
        end else if (do_chain) begin
            chain_reg <= data[quad_dac_pkg::CHAIN_BIT];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mask_reg <= quad_dac_pkg::MASK_RST;
        end else if (do_swrst) begin
            mask_reg <= quad_dac_pkg::MASK_RST;
        end else if (do_mask) begin
            mask_reg <= data[quad_dac_pkg::MASK_MSB:0];
        end
    end

    // Address bits play no part in a power command
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            power_mode_reg <= quad_dac_pkg::PWR_RST;
        end else if (do_swrst) begin
            power_mode_reg <= quad_dac_pkg::PWR_RST;
        end else if (do_power) begin
            power_mode_reg <= data[quad_dac_pkg::PWR_MSB:0];
        end
    end

    assign pw.load     = do_power;
    assign pw.soft_rst = do_swrst;
    assign pw.modes    = data[quad_dac_pkg::PWR_MSB:0];

    // ********************************
    // Input and DAC registers
    // ********************************
    logic [15:0] in_reg  [quad_dac_pkg::NCH];
    logic [15:0] dac_reg [quad_dac_pkg::NCH];

    for (genvar i = 0; i < quad_dac_pkg::NCH; i++) begin : g_ch
        wire sel_ch   = addr[i];
        wire in_we    = (do_wr_in || do_wr_upd) && sel_ch;
        // Direct write ignores the load pin; a low pin makes the input stage transparent
        wire dac_data = (do_wr_upd || (do_wr_in && load_low)) && sel_ch;
        // A masked channel ignores a load fall; a low load pin still passes input writes
        wire dac_copy = (do_update && sel_ch) || (load_fall && !mask_reg[i]);

        always_ff @(posedge i_core_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                in_reg[i] <= quad_dac_pkg::CODE_RST;
            end else if (do_swrst) begin
                in_reg[i] <= quad_dac_pkg::CODE_RST;
            end else if (in_we) begin
                in_reg[i] <= data;
            end
        end

        // Power state never touches these registers
        always_ff @(posedge i_core_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                dac_reg[i] <= quad_dac_pkg::CODE_RST;
            end else if (do_swrst) begin
                dac_reg[i] <= quad_dac_pkg::CODE_RST;
            end else if (dac_data) begin
                dac_reg[i] <= data;
            end else if (dac_copy) begin
                dac_reg[i] <= in_reg[i];
            end
        end

        assign o_dac_code[i] = dac_reg[i];
    end

    // ********************************
    // Readback
    // ********************************
    // Exactly one address bit picks a channel, else channel A
    wire       addr_onehot = (addr != 4'h0) && ((addr & (addr - 4'h1)) == 4'h0);
    wire [1:0] addr_idx    = addr[3] ? 2'h3 : addr[2] ? 2'h2 : addr[1] ? 2'h1 : 2'h0;
    wire [1:0] rb_idx      = addr_onehot ? addr_idx : 2'h0;

    logic [23:0] rb_word_reg;
    logic        rb_active_reg;

    // Both change only at a frame end, while the link clock is still
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rb_word_reg <= 24'h000000;
        end else if (do_rdbk) begin
            rb_word_reg <= {quad_dac_pkg::RB_PAD, dac_reg[rb_idx], quad_dac_pkg::RB_PAD};
        end
    end

    // Active for exactly the frame that follows the request
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rb_active_reg <= 1'b0;
        end else if (frame_done) begin
            rb_active_reg <= do_rdbk && !do_swrst;
        end
    end

    assign lk.rb_word   = rb_word_reg;
    assign lk.rb_active = rb_active_reg;

    // ********************************
    // Outputs
    // ********************************
    assign o_serial_out_oe_n = !(chain_reg || rb_active_reg);
    assign o_chain_enable    = chain_reg;
    assign o_power_mode      = power_mode_reg;
    assign o_pd_1k           = pw.pd_1k;
    assign o_pd_100k         = pw.pd_100k;
    assign o_pd_hiz          = pw.pd_hiz;
    assign o_out_valid       = pw.valid;

endmodule : quad_dac_ctrl

`default_nettype wire

// [core/quad_dac_pkg.sv]
// Constants for the quad DAC serial command control block.
// Assumes a 50 MHz core clock and a 24-bit frame on the serial link.
package quad_dac_pkg;

    // ********************************
    // Frame layout
    // ********************************
    localparam int FRAME_BITS = 24;
    localparam int POS_W      = 5;
    localparam int NCH        = 4;
    localparam int CODE_W     = 16;
    localparam int CMD_MSB    = 23;
    localparam int CMD_LSB    = 20;
    localparam int ADDR_MSB   = 19;
    localparam int ADDR_LSB   = 16;
    localparam int DATA_MSB   = 15;
    localparam int DATA_LSB   = 0;
    localparam int CHAIN_BIT  = 0;
    localparam int MASK_MSB   = 3;
    localparam int PWR_MSB    = 7;

    // ********************************
    // Command codes
    // ********************************
    localparam logic [3:0] CMD_NOP    = 4'h0;
    localparam logic [3:0] CMD_WR_IN  = 4'h1;
    localparam logic [3:0] CMD_UPDATE = 4'h2;
    localparam logic [3:0] CMD_WR_UPD = 4'h3;
    localparam logic [3:0] CMD_POWER  = 4'h4;
    localparam logic [3:0] CMD_MASK   = 4'h5;
    localparam logic [3:0] CMD_SWRST  = 4'h6;
    localparam logic [3:0] CMD_CHAIN  = 4'h8;
    localparam logic [3:0] CMD_RDBK   = 4'h9;

    // ********************************
    // Power modes and reset values
    // ********************************
    localparam logic [1:0]  PD_NORMAL = 2'h0;
    localparam logic [1:0]  PD_1K     = 2'h1;
    localparam logic [1:0]  PD_100K   = 2'h2;
    localparam logic [1:0]  PD_HIZ    = 2'h3;
    localparam logic        CHAIN_RST = 1'h0;
    localparam logic [3:0]  MASK_RST  = 4'h0;
    localparam logic [7:0]  PWR_RST   = 8'h00;
    localparam logic [15:0] CODE_RST  = 16'h0000;
    localparam logic [3:0]  RB_PAD    = 4'h0;

    // ********************************
    // Timing
    // ********************************
    localparam int         CORE_CLK_MHZ = 50;
    localparam int         WAKE_TIME_NS = 4500;
    localparam int         WAKE_W       = 8;
    localparam logic [7:0] WAKE_CYCLES  = 8'((WAKE_TIME_NS * CORE_CLK_MHZ + 999) / 1000);

endpackage : quad_dac_pkg

// [core/dac_ifs.sv]
// Carriers between the control core and its two helper modules.
// Assumes quad_dac_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none

interface link_if;
    logic [23:0] frame;
    logic [23:0] rb_word;
    logic        rb_active;
    modport shift (output frame, input rb_word, input rb_active);
    modport core  (input frame, output rb_word, output rb_active);
endinterface : link_if

interface pwr_if;
    logic       load;
    logic       soft_rst;
    logic [7:0] modes;
    logic [3:0] valid;
    logic [3:0] pd_1k;
    logic [3:0] pd_100k;
    logic [3:0] pd_hiz;
    modport ctrl (output load, soft_rst, modes, input valid, pd_1k, pd_100k, pd_hiz);
    modport bank (input load, soft_rst, modes, output valid, pd_1k, pd_100k, pd_hiz);
endinterface : pwr_if

`default_nettype wire

// [core/serial_shifter.sv]
// Serial-clock side: input shift register and serial output.
// Assumes the serial clock stops while the frame select is high.
`timescale 1ns/1ps
`default_nettype none

module serial_shifter (
    // Link
    input  wire logic  i_sclk,
    input  wire logic  i_resetn,
    input  wire logic  i_frame_sel_n,
    input  wire logic  i_serial_in,
    output logic       o_serial_out,
    // Core side
    link_if.shift      lk
);
    logic [23:0] shift_reg;
    logic [4:0]  bit_pos_reg;
    logic        chain_out_reg;

    // Shift on falling edges only inside a frame
    always_ff @(negedge i_sclk or negedge i_resetn) begin
        if (!i_resetn) begin
            shift_reg <= 24'h000000;
        end else if (!i_frame_sel_n) begin
            shift_reg <= {shift_reg[22:0], i_serial_in};
        end
    end

    // Output bit index, cleared by the frame select itself
    always_ff @(posedge i_sclk or negedge i_resetn or posedge i_frame_sel_n) begin
        if (!i_resetn) begin
            bit_pos_reg <= 5'h00;
        end else if (i_frame_sel_n) begin
            bit_pos_reg <= 5'h00;
        end else if (bit_pos_reg != 5'(quad_dac_pkg::FRAME_BITS - 1)) begin
            bit_pos_reg <= bit_pos_reg + 5'h01;
        end
    end

    always_ff @(posedge i_sclk or negedge i_resetn) begin
        if (!i_resetn) begin
            chain_out_reg <= 1'b0;
        end else begin
            chain_out_reg <= shift_reg[23];
        end
    end

    wire [4:0] rb_idx = 5'(quad_dac_pkg::FRAME_BITS - 1) - bit_pos_reg;

    assign lk.frame     = shift_reg;
    assign o_serial_out = lk.rb_active ? lk.rb_word[rb_idx] : chain_out_reg;

endmodule : serial_shifter

`default_nettype wire

// [core/power_ctrl.sv]
// Per-channel power mode store, mode decode and wake-up timing.
// Assumes one-cycle load and soft reset strobes from the core.
`timescale 1ns/1ps
`default_nettype none

module power_ctrl (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_resetn,
    // Core side
    pwr_if.bank       pw
);
    for (genvar i = 0; i < quad_dac_pkg::NCH; i++) begin : g_ch
        logic [1:0] mode_reg;
        logic [7:0] wake_reg;
        logic       valid_reg;
        wire  [1:0] mode_new = pw.modes[2*i+1:2*i];
        wire        waking   = pw.load && (mode_new == quad_dac_pkg::PD_NORMAL)
                               && (mode_reg != quad_dac_pkg::PD_NORMAL);

        always_ff @(posedge i_core_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                mode_reg <= quad_dac_pkg::PD_NORMAL;
                wake_reg <= 8'h00;
            end else if (pw.soft_rst) begin
                mode_reg <= quad_dac_pkg::PD_NORMAL;
                wake_reg <= 8'h00;
            end else begin
                if (pw.load) begin
                    mode_reg <= mode_new;
                end
                if (waking) begin
                    wake_reg <= quad_dac_pkg::WAKE_CYCLES;
                end else if (wake_reg != 8'h00) begin
                    wake_reg <= wake_reg - 8'h01;
                end
            end
        end

        always_ff @(posedge i_core_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                valid_reg <= 1'b1;
            end else begin
                valid_reg <= (mode_reg == quad_dac_pkg::PD_NORMAL) && (wake_reg == 8'h00) && !waking;
            end
        end

        assign pw.valid[i]   = valid_reg;
        assign pw.pd_1k[i]   = (mode_reg == quad_dac_pkg::PD_1K);
        assign pw.pd_100k[i] = (mode_reg == quad_dac_pkg::PD_100K);
        assign pw.pd_hiz[i]  = (mode_reg == quad_dac_pkg::PD_HIZ);
    end

endmodule : power_ctrl

`default_nettype wire

// [tb/quad_dac_props.sv]
// Concurrent checks on the ports of the quad DAC control top.
// Assumes one core clock domain with an active-low async reset.
`timescale 1ns/1ps
`default_nettype none

module quad_dac_props (
    // Clock and reset
    input wire logic             i_core_clk,
    input wire logic             i_resetn,
    // Link
    input wire logic             i_frame_sel_n,
    input wire logic             o_serial_out_oe_n,
    // Channel outputs
    input wire logic [3:0][15:0] o_dac_code,
    input wire logic [7:0]       o_power_mode,
    input wire logic [3:0]       o_pd_1k,
    input wire logic [3:0]       o_pd_100k,
    input wire logic [3:0]       o_pd_hiz,
    input wire logic [3:0]       o_out_valid,
    input wire logic             o_chain_enable
);
    // ********************************
    // Helper logic
    // ********************************
    logic [3:0] m01, m10, m11, nz;
    logic [3:0] low_cnt;
    logic [8:0] wake_cnt;
    wire        wake_run = (o_power_mode[1:0] == quad_dac_pkg::PD_NORMAL) && !o_out_valid[0];

    for (genvar i = 0; i < 4; i++) begin : g_mode
        assign m01[i] = (o_power_mode[2*i +: 2] == quad_dac_pkg::PD_1K);
        assign m10[i] = (o_power_mode[2*i +: 2] == quad_dac_pkg::PD_100K);
        assign m11[i] = (o_power_mode[2*i +: 2] == quad_dac_pkg::PD_HIZ);
        assign nz[i]  = (o_power_mode[2*i +: 2] != quad_dac_pkg::PD_NORMAL);
    end

    // Cycles with select low, and cycles of channel A waking up
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            low_cnt  <= 4'h0;
            wake_cnt <= 9'h000;
        end else begin
            low_cnt  <= i_frame_sel_n ? 4'h0 : ((low_cnt == 4'hf) ? low_cnt : low_cnt + 4'h1);
            wake_cnt <= wake_run ? wake_cnt + 9'h001 : 9'h000;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    // ********************************
    // Assertions
    // ********************************
    pd_1k_a: assert property (o_pd_1k == m01)
        else $error("pd_1k does not match stored mode");
    pd_100k_a: assert property (o_pd_100k == m10)
        else $error("pd_100k does not match stored mode");
    pd_hiz_a: assert property (o_pd_hiz == m11)
        else $error("pd_hiz does not match stored mode");
    valid_mode_a: assert property ((o_out_valid & nz & $past(nz)) == 4'h0)
        else $error("output valid while powered down");
    wake_min_a: assert property ($rose(o_out_valid[0]) |-> $past(wake_cnt) >= 9'(quad_dac_pkg::WAKE_CYCLES))
        else $error("wake-up shorter than expected");
    wake_max_a: assert property (wake_cnt <= 9'(quad_dac_pkg::WAKE_CYCLES) + 9'h001)
        else $error("wake-up longer than expected");
    frame_quiet_a: assert property (low_cnt >= 4'h6 |-> $stable(o_dac_code) && $stable(o_power_mode))
        else $error("registers changed while frame open");
    chain_when_a: assert property ($changed(o_chain_enable) |-> i_frame_sel_n && $past(i_frame_sel_n, 3))
        else $error("chain enable changed outside frame end");
    chain_oe_a: assert property (o_chain_enable && $past(o_chain_enable) |-> !o_serial_out_oe_n)
        else $error("serial out not driven in chain mode");
    oe_fall_a: assert property ($fell(o_serial_out_oe_n) |-> i_frame_sel_n)
        else $error("serial out enabled during frame");

    chain_on_c: cover property ($rose(o_chain_enable));
    readback_c: cover property ($fell(o_serial_out_oe_n) && !o_chain_enable);
    wake_c: cover property ($rose(o_out_valid[0]));
endmodule : quad_dac_props

bind quad_dac_ctrl quad_dac_props props_u (
    .i_core_clk, .i_resetn, .i_frame_sel_n, .o_serial_out_oe_n, .o_dac_code, .o_power_mode,
    .o_pd_1k, .o_pd_100k, .o_pd_hiz, .o_out_valid, .o_chain_enable
);

`default_nettype wire

// [tb/spi_host_model.sv]
// Host serial master: gated 30 ns burst clock, idle high, stopped between frames.
// The caller need not space frames; each transfer leaves a 200 ns select-high gap.
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
    // Link
    output logic     o_sclk,
    output logic     o_frame_sel_n,
    output logic     o_serial_in,
    input wire logic i_serial_out
);
    initial begin
        o_sclk        = 1'b1;
        o_frame_sel_n = 1'b1;
        o_serial_in   = 1'b0;
    end

    // Shift the low n bits of d MSB first; serial out sampled before each falling edge
    task automatic xfer(input logic [47:0] d, input int n, output logic [47:0] rx);
        rx = 48'h0;
        o_frame_sel_n = 1'b0;
        #15;
        for (int k = n - 1; k >= 0; k--) begin
            o_serial_in = d[k];
            #7.5;
            rx = {rx[46:0], i_serial_out};
            o_sclk = 1'b0;
            #15;
            o_sclk = 1'b1;
            #7.5;
        end
        #15;
        o_frame_sel_n = 1'b1;
        o_serial_in = ~o_serial_in;
        #200;
    endtask : xfer
endmodule : spi_host_model

`default_nettype wire

// [tb/tb_quad_dac_serial_command_control.sv]
// Self-checking bench for the quad DAC control top against a behavioural model.
// Assumes the host model drives the link and the bench drives clock, reset and load pin.
`timescale 1ns/1ps
`default_nettype none

module tb_quad_dac_serial_command_control;
    logic             i_core_clk, i_resetn, i_load_update_n;
    logic             sclk, sel_n, serial_in, serial_out, sdo_oe_n, chain;
    logic [3:0][15:0] dac_code;
    logic [7:0]       pmode, m_pm;
    logic [3:0]       pd1k, pd100k, pdhiz, ovalid, m_mask;
    logic [15:0]      m_in [4];
    logic [15:0]      m_dac [4];
    logic             m_chain, m_rb;
    logic [31:0]      rng;
    logic [47:0]      rx;
    logic [23:0]      fx, fy;
    int               fail_count, check_count, cycles;
    logic [3:0]       rb_addr [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h0};
    int               rb_idx [6]  = '{0, 1, 2, 3, 0, 0};

    quad_dac_ctrl dut_u (
        .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_sclk(sclk), .i_frame_sel_n(sel_n),
        .i_serial_in(serial_in), .o_serial_out(serial_out), .o_serial_out_oe_n(sdo_oe_n),
        .i_load_update_n(i_load_update_n), .o_dac_code(dac_code), .o_power_mode(pmode),
        .o_pd_1k(pd1k), .o_pd_100k(pd100k), .o_pd_hiz(pdhiz), .o_out_valid(ovalid),
        .o_chain_enable(chain)
    );
    spi_host_model host_u (.o_sclk(sclk), .o_frame_sel_n(sel_n), .o_serial_in(serial_in), .i_serial_out(serial_out));

    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic finish_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic model_frame(input logic [23:0] f);
        logic [3:0] c;
        c = f[23:20];
        for (int i = 0; i < 4; i++) begin
            if (f[16+i] && (c == quad_dac_pkg::CMD_UPDATE)) m_dac[i] = m_in[i];
            if (f[16+i] && (c == quad_dac_pkg::CMD_WR_IN || c == quad_dac_pkg::CMD_WR_UPD)) m_in[i] = f[15:0];
            if (f[16+i] && (c == quad_dac_pkg::CMD_WR_UPD || (c == quad_dac_pkg::CMD_WR_IN && !i_load_update_n)))
                m_dac[i] = f[15:0];
        end
        if (c == quad_dac_pkg::CMD_POWER) m_pm = f[7:0];
        if (c == quad_dac_pkg::CMD_MASK) m_mask = f[3:0];
        if (c == quad_dac_pkg::CMD_CHAIN) m_chain = f[0];
        if (c == quad_dac_pkg::CMD_SWRST) begin
            m_in = '{default: 16'h0};
            m_dac = '{default: 16'h0};
            {m_mask, m_pm, m_chain} = '0;
        end
        m_rb = (c == quad_dac_pkg::CMD_RDBK);
    endtask : model_frame

    task automatic check_all();
        for (int i = 0; i < 4; i++) chk("dac_code", 24'(m_dac[i]), 24'(dac_code[i]));
        chk("power_mode", 24'(m_pm), 24'(pmode));
        chk("chain_enable", 24'(m_chain), 24'(chain));
        chk("serial_out_oe_n", 24'(!(m_chain || m_rb)), 24'(sdo_oe_n));
        for (int i = 0; i < 4; i++)
            chk("pd_decode", 24'((1 << m_pm[2*i +: 2]) >> 1), 24'({pdhiz[i], pd100k[i], pd1k[i]}));
    endtask : check_all

    task automatic send(input logic [23:0] f);
        host_u.xfer({24'h0, f}, 24, rx);
        model_frame(f);
        check_all();
    endtask : send

    task automatic pulse_load();
        @(posedge i_core_clk);
        i_load_update_n <= 1'b0;
        for (int i = 0; i < 4; i++) if (!m_mask[i]) m_dac[i] = m_in[i];
        repeat (10) @(posedge i_core_clk);
        i_load_update_n <= 1'b1;
        repeat (10) @(posedge i_core_clk);
        check_all();
    endtask : pulse_load

    initial begin
        i_resetn = 1'b0;
        i_load_update_n = 1'b1;
        rng = 32'h0000003e;
        m_in = '{default: 16'h0};
        m_dac = '{default: 16'h0};
        {m_mask, m_pm, m_chain, m_rb} = '0;
        repeat (4) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        repeat (6) @(posedge i_core_clk);
        check_all();
        chk("out_valid", 24'hf, 24'(ovalid));
        rng = xs(rng);
        send({8'h3f, rng[15:0]});
        rng = xs(rng);
        send({8'h12, rng[15:0]});
        pulse_load();
        send(24'h500001);
        rng = xs(rng);
        send({8'h13, rng[15:0]});
        pulse_load();
        send(24'h500000);
        pulse_load();
        @(posedge i_core_clk);
        i_load_update_n <= 1'b0;
        repeat (10) @(posedge i_core_clk);
        rng = xs(rng);
        send({8'h1c, rng[15:0]});
        @(posedge i_core_clk);
        i_load_update_n <= 1'b1;
        for (int c = 0; c < 16; c++) if (c == 0 || c == 7 || c > 9) send({4'(c), 20'hfdead});
        send(24'h4a00e5);
        chk("out_valid", 24'h0, 24'(ovalid));
        rng = xs(rng);
        send({8'h3f, rng[15:0]});
        send(24'h400000);
        repeat (200) @(posedge i_core_clk);
        chk("out_valid", 24'h0, 24'(ovalid));
        repeat (40) @(posedge i_core_clk);
        chk("out_valid", 24'hf, 24'(ovalid));
        for (int j = 0; j < 6; j++) begin
            send({4'h9, rb_addr[j], 16'hffff});
            send(24'h000000);
            chk("readback", 24'(m_dac[rb_idx[j]]), 24'(rx[19:4]));
        end
        send(24'h800001);
        rng = xs(rng);
        fx = {8'h3f, rng[31:16]};
        fy = {8'h3f, rng[15:0]};
        host_u.xfer({fx, fy}, 48, rx);
        model_frame(fy);
        check_all();
        chk("chain_out", fx, rx[23:0]);
        rng = xs(rng);
        fy = {8'h3f, rng[15:0]};
        host_u.xfer({23'h0, 1'b1, fy}, 25, rx);
        model_frame(fy);
        check_all();
        send(24'h800000);
        rng = xs(rng);
        send({8'h1a, rng[15:0]});
        send(24'h220000);
        send(24'h600000);
        finish_test();
    end
endmodule : tb_quad_dac_serial_command_control

`default_nettype wire
